// ==== shared/hb_pkg.sv ====
/*
 Constants, field layout, cycle states and the pin bundle of the 16-bit
 non-multiplexed host-bus port. Assumes a 25 MHz clock and an APB master.
*/
package hb_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_TOP    = 8'h00;
   localparam logic [7:0] OFS_CFG    = 8'h04;
   localparam logic [7:0] OFS_CFG2   = 8'h08;
   localparam logic [7:0] OFS_ADDR   = 8'h0c;
   localparam logic [7:0] OFS_WDATA  = 8'h10;
   localparam logic [7:0] OFS_CMD    = 8'h14;
   localparam logic [7:0] OFS_RDATA  = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   // Field positions
   localparam int unsigned TOP_MODE_LSB = 0;
   localparam int unsigned HB_MODE_LSB  = 0;
   localparam int unsigned HB_BYTE_LANE_SELECT_LSB  = 4;
   localparam int unsigned HB_WAIT_LSB  = 8;
   localparam int unsigned CS_CFG_LSB   = 0;
   localparam int unsigned CMD_WR_BIT   = 0;
   localparam int unsigned CMD_SEL_LSB  = 1;
   localparam int unsigned CMD_BE_LSB   = 4;
   localparam int unsigned ST_BUSY_BIT  = 0;
   localparam int unsigned ST_REF_BIT   = 1;
   localparam int unsigned ST_RDY_BIT   = 2;
   // Field values and reset values
   localparam logic [3:0] TOP_MODE_HB16  = 4'h3;
   localparam logic [1:0] HB_MODE_NONMUX = 2'h1;
   localparam logic [1:0] BYTE_LANE_SELECT_ON        = 2'h0;
   localparam logic [1:0] BYTE_LANE_SELECT_OFF       = 2'h1;
   localparam logic [2:0] CS_ALE         = 3'h0;
   localparam logic [2:0] CS_ONE         = 3'h1;
   localparam logic [2:0] CS_TWO         = 3'h2;
   localparam logic [2:0] CS_ALE_TWO     = 3'h3;
   localparam logic [2:0] CS_FOUR        = 3'h5;
   localparam logic [2:0] CS_THREE       = 3'h7;
   localparam logic [3:0] TOP_RST        = 4'h0;
   localparam logic [1:0] HB_MODE_RST    = 2'h0;
   localparam logic [1:0] BYTE_LANE_SELECT_RST       = 2'h0;
   localparam logic [1:0] WAIT_RST       = 2'h0;
   localparam logic [2:0] CS_RST         = 3'h0;
   // Pin geometry
   localparam int unsigned ADDR_W     = 22;
   localparam logic [4:0]  REACH_BASE = 5'h0c;
   localparam logic [4:0]  REACH_EXT  = 5'h16;
   localparam logic [4:0]  BYTE_LANE_SELECT_PINS  = 5'h02;
   // Timing in clock cycles; covers the input synchroniser lag
   localparam logic [3:0]  STROBE_MIN = 4'h5;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_HOLD
   } hb_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              ale;
      logic [3:0]        sel_n;
      logic [1:0]        byte_lane_select_n;
      logic              rd_n;
      logic              wr_n;
      logic              ext_en;
   } hb_pins_t;
endpackage

// ==== verification/hb_periph_model.sv ====
/*
 Behavioural peripheral on the far side of the host-bus port: a small
 memory behind an address latch, with a ready line that can lag.
 Assumes the pin bundle of hb_pkg and a bench that sets the lag.
*/
`timescale 1ns/10ps
`default_nettype none
module hb_periph_model (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire hb_pkg::hb_pins_t pins,
   input  wire logic [15:0]      data_out,
   input  wire logic             data_oe,
   input  wire logic [7:0]       slow,
   output logic      [15:0]      data_in,
   output logic                  ready_in
);
   logic [15:0] mem [0:255];
   logic [21:0] lat;
   logic [7:0]  cnt;
   logic [15:0] noise;
   wire logic       strobe = !pins.rd_n || !pins.wr_n;
   // No byte selects means a whole-word cycle
   wire logic [1:0] lanes = (&pins.byte_lane_select_n) ? 2'h3 : ~pins.byte_lane_select_n;
   wire logic       wr_now = !pins.wr_n && data_oe;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt   <= 8'h00;
         lat   <= 22'h0;
         noise <= 16'h5a5a;
      end else begin
         noise <= ~noise;
         if (pins.ale || !(&pins.sel_n)) lat <= pins.addr;
         cnt <= strobe ? cnt + 8'h01 : 8'h00;
         if (wr_now && lanes[0]) mem[lat[7:0]][7:0] <= data_out[7:0];
         if (wr_now && lanes[1]) mem[lat[7:0]][15:8] <= data_out[15:8];
      end
   end

   // Undriven data toggles so a stale value can never look right
   assign data_in  = pins.rd_n ? noise : mem[lat[7:0]];
   assign ready_in = !strobe || (cnt >= slow);
endmodule // hb_periph_model
`default_nettype wire

// ==== verification/testbench.sv ====
/*
 Self-checking bench for the host-bus port: APB master, pin monitor and
 random cycles in every select mode. Assumes hb_periph_model on the pins.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic             clock, rst_n, ce, psel, penable, pwrite, e, strobe_q;
   logic             pready, pslverr, data_oe, ready_in;
   logic [7:0]       paddr, slow;
   logic [31:0]      pwdata, prdata, q;
   logic [15:0]      data_out, data_in;
   logic [21:0]      addr_seen;
   logic [3:0]       sel_seen;
   logic [1:0]       byte_lane_select_seen;
   hb_pkg::hb_pins_t pins;
   int fails = 0, num_checks = 0, cyc_cnt = 0, ale_cnt = 0, slen = 0;
   logic [2:0] fl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
   int         cn [6] = '{1, 1, 2, 2, 3, 4};

   hb_host16_port dut_u (.clock(clock), .rst_n(rst_n), .ce(ce), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_pins(pins),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
      .ready_in(ready_in));
   hb_periph_model peer_u (.clock(clock), .rst_n(rst_n), .pins(pins),
      .data_out(data_out), .data_oe(data_oe), .slow(slow),
      .data_in(data_in), .ready_in(ready_in));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic check(input string n, input logic [31:0] s,
                        input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         fails++;
         $display("FAIL %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_idle;
      int i;
      i = 0;
      do begin
         apb(1'b0, hb_pkg::OFS_STATUS, 32'h0);
         i++;
      end while (q[0] !== 1'b0 && i < 100);
      check("busy", {31'h0, q[0]}, 32'h0);
   endtask

   task automatic op(input logic w, input logic [1:0] idx,
                     input logic [1:0] be,
                     input logic [21:0] a, input logic [15:0] d);
      apb(1'b1, hb_pkg::OFS_ADDR, {10'h0, a});
      apb(1'b1, hb_pkg::OFS_WDATA, {16'h0, d});
      apb(1'b1, hb_pkg::OFS_CMD, {26'h0, be, 1'b0, idx, w});
      wait_idle;
   endtask

   task automatic setup(input logic [2:0] f, input logic bon,
                        input logic [1:0] wt);
      apb(1'b1, hb_pkg::OFS_TOP, {28'h0, hb_pkg::TOP_MODE_HB16});
      apb(1'b1, hb_pkg::OFS_CFG, {22'h0, wt, 2'h0,
          bon ? hb_pkg::BYTE_LANE_SELECT_ON : hb_pkg::BYTE_LANE_SELECT_OFF, 2'h0,
          hb_pkg::HB_MODE_NONMUX});
      apb(1'b1, hb_pkg::OFS_CFG2, {29'h0, f});
   endtask

   task automatic refused(input string n, input logic x);
      apb(1'b0, hb_pkg::OFS_STATUS, 32'h0);
      check(n, {31'h0, q[1]}, {31'h0, x});
      apb(1'b1, hb_pkg::OFS_STATUS, 32'h2);
   endtask

   task automatic cycle(input logic [2:0] f, input logic bon, input int n);
      logic [21:0] a;
      logic [15:0] w1, w2, x;
      logic [1:0]  be, idx, wt;
      int          c0, a0, r;
      a = 22'($urandom);
      w1 = 16'($urandom);
      w2 = 16'($urandom);
      be = 2'($urandom % 3 + 1);
      idx = 2'($urandom % n);
      wt = 2'($urandom);
      r = (f == 3'h2) ? 11 : (f == 3'h3) ? 10 : (f > 3'h3) ? 22 : 12;
      if (bon) r -= 2;
      x = bon ? {be[1] ? w2[15:8] : w1[15:8], be[0] ? w2[7:0] : w1[7:0]} : w2;
      setup(f, bon, wt);
      c0 = cyc_cnt;
      a0 = ale_cnt;
      op(1'b1, idx, 2'h3, a, w1);
      op(1'b1, idx, be, a, w2);
      check("byte_lane_select", {30'h0, byte_lane_select_seen},
            {30'h0, bon ? 2'(~be) : 2'h3});
      op(1'b0, idx, 2'h3, a, 16'h0);
      apb(1'b0, hb_pkg::OFS_RDATA, 32'h0);
      check("rdata", q, {16'h0, x});
      check("strobes", cyc_cnt - c0, 3);
      check("ale", ale_cnt - a0,
            (f == 3'h0 || f == 3'h3) ? 3 : 0);
      check("sel", {28'h0, sel_seen},
            {28'h0, f == 3'h0 ? 4'hf : 4'(~(4'h1 << idx))});
      check("addr", {10'h0, addr_seen},
            {10'h0, a & 22'((23'h1 << r) - 1)});
      check("ext", {31'h0, pins.ext_en}, {31'h0, f[2]});
      check("len", slen, 5 + wt);
   endtask

   always @(posedge clock) begin
      if (rst_n) begin
         check("overlap", {31'h0, pins.rd_n | pins.wr_n}, 32'h1);
         if (pins.ale) ale_cnt++;
         if (!pins.rd_n || !pins.wr_n) begin
            if (!strobe_q) begin
               cyc_cnt++;
               slen = 0;
               addr_seen = pins.addr;
               sel_seen = pins.sel_n;
               byte_lane_select_seen = pins.byte_lane_select_n;
            end else
               check("hold", {4'h0, pins.addr, pins.sel_n, pins.byte_lane_select_n},
                     {4'h0, addr_seen, sel_seen, byte_lane_select_seen});
            slen++;
         end
         strobe_q = !pins.rd_n || !pins.wr_n;
      end
   end

   initial begin
      repeat (50000) @(posedge clock);
      fails++;
      tally_and_finish;
   end

   initial begin
      int c;
      rst_n = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slow = 8'h00;
      strobe_q = 1'b0;
      void'($urandom(13635));
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      check("idle", {22'h0, pins.sel_n, pins.byte_lane_select_n, pins.rd_n, pins.wr_n,
            pins.ale, data_oe}, 32'h3fc);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check("reset", q, 32'h0);
      end
      apb(1'b0, 8'h20, 32'h0);
      check("slverr", {31'h0, e}, 32'h1);
      check("unmapped", q, 32'h0);
      c = cyc_cnt;
      setup(3'h1, 1'b1, 2'h0);
      apb(1'b1, hb_pkg::OFS_TOP, 32'h0);
      op(1'b0, 2'h0, 2'h3, 22'h0, 16'h0);
      refused("top", 1'b1);
      setup(3'h1, 1'b1, 2'h0);
      apb(1'b1, hb_pkg::OFS_CFG, 32'h0);
      op(1'b0, 2'h0, 2'h3, 22'h0, 16'h0);
      refused("muxed", 1'b1);
      check("gated", cyc_cnt - c, 0);
      for (int i = 0; i < 6; i++)
         for (int b = 0; b < 2; b++) cycle(fl[i], b[0], cn[i]);
      setup(3'h1, 1'b0, 2'h0);
      op(1'b0, 2'h1, 2'h3, 22'h0, 16'h0);
      refused("idx", 1'b1);
      setup(3'h4, 1'b0, 2'h0);
      op(1'b0, 2'h0, 2'h3, 22'h0, 16'h0);
      refused("rsv", 1'b1);
      setup(3'h5, 1'b0, 2'h0);
      op(1'b0, 2'h3, 2'h3, 22'h0, 16'h0);
      refused("four", 1'b0);
      c = cyc_cnt;
      apb(1'b1, hb_pkg::OFS_CMD, 32'h30);
      apb(1'b1, hb_pkg::OFS_CMD, 32'h30);
      wait_idle;
      refused("busy", 1'b1);
      check("single", cyc_cnt - c, 1);
      // Clock enable low mid-strobe must stretch the strobe, pins held
      apb(1'b1, hb_pkg::OFS_CMD, 32'h30);
      @(posedge clock);
      ce <= 1'b0;
      repeat (6) @(posedge clock);
      ce <= 1'b1;
      wait_idle;
      check("freeze", slen, 11);
      slow <= 8'd12;
      setup(3'h2, 1'b0, 2'h0);
      op(1'b0, 2'h1, 2'h3, 22'h5, 16'h0);
      check("stretch", {31'h0, slen >= 12}, 32'h1);
      setup(3'h0, 1'b0, 2'h0);
      op(1'b0, 2'h0, 2'h3, 22'h5, 16'h0);
      check("noready", slen, 5);
      tally_and_finish;
   end
endmodule // testbench
`default_nettype wire

// ==== verilog/hb_host16_port.sv ====
/*
 16-bit non-multiplexed host-bus port with an APB register file.
 Assumes an APB master on clock and external parts that answer on pins.
*/
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module hb_host16_port (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output var hb_pkg::hb_pins_t bus_pins,
   output logic      [15:0] data_out,
   output logic             data_oe,
   input  wire logic [15:0] data_in,
   input  wire logic        ready_in
);
   // Configuration and request registers
   logic [3:0]  iface_top_config;
   logic [1:0]  hb_mode;
   logic [1:0]  byte_sel_cfg;
   logic [1:0]  wait_cfg;
   logic [2:0]  select_config_field;
   logic [21:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic        refused;
   // Latched cycle
   hb_pkg::hb_state_t state;
   hb_pkg::hb_state_t next_state;
   logic [3:0]  cnt;
   logic        cyc_write;
   logic        cyc_ale;
   logic        cyc_rdy;
   logic [1:0]  cyc_wait;
   logic [21:0] cyc_addr;
   logic [3:0]  cyc_sel_n;
   logic [1:0]  cyc_byte_lane_select_n;
   logic [15:0] cyc_wdata;
   logic        ready_s;
   logic [15:0] data_s;
   logic [31:0] rd_mux;

   hb_sync #(.WIDTH(1)) u_rdy_sync (
      .clock      (clock),
      .rst_n      (rst_n),
      .ce         (ce),
      .async_in   (ready_in),
      .stable_out (ready_s)
   );

   hb_sync #(.WIDTH(16)) u_data_sync (
      .clock      (clock),
      .rst_n      (rst_n),
      .ce         (ce),
      .async_in   (data_in),
      .stable_out (data_s)
   );

   // APB decode
   wire logic wr_acc   = psel & penable & pwrite;
   wire logic hit_top  = (paddr == hb_pkg::OFS_TOP);
   wire logic hit_cfg  = (paddr == hb_pkg::OFS_CFG);
   wire logic hit_cfg2 = (paddr == hb_pkg::OFS_CFG2);
   wire logic hit_addr = (paddr == hb_pkg::OFS_ADDR);
   wire logic hit_wd   = (paddr == hb_pkg::OFS_WDATA);
   wire logic hit_cmd  = (paddr == hb_pkg::OFS_CMD);
   wire logic hit_rd   = (paddr == hb_pkg::OFS_RDATA);
   wire logic hit_st   = (paddr == hb_pkg::OFS_STATUS);
   wire logic hit_any  = hit_top | hit_cfg | hit_cfg2 | hit_addr | hit_wd
                       | hit_cmd | hit_rd | hit_st;
   wire logic wr_stat  = wr_acc & hit_st;
   wire logic start_req = wr_acc & hit_cmd;

   // Mode decode
   wire logic mode_ok = (iface_top_config == hb_pkg::TOP_MODE_HB16)
                      && (hb_mode == hb_pkg::HB_MODE_NONMUX);
   wire logic byte_lane_select_on = (byte_sel_cfg == hb_pkg::BYTE_LANE_SELECT_ON);
   wire logic cs_ale  = (select_config_field == hb_pkg::CS_ALE);
   wire logic cs_one  = (select_config_field == hb_pkg::CS_ONE);
   wire logic cs_two  = (select_config_field == hb_pkg::CS_TWO);
   wire logic cs_at   = (select_config_field == hb_pkg::CS_ALE_TWO);
   wire logic cs_four = (select_config_field == hb_pkg::CS_FOUR);
   wire logic cs_thr  = (select_config_field == hb_pkg::CS_THREE);
   // Select options per field value
   wire logic       ale_cfg = cs_ale | cs_at;
   wire logic [2:0] sel_count = cs_four ? 3'h4 : cs_thr ? 3'h3 :
                                (cs_two | cs_at) ? 3'h2 :
                                cs_one ? 3'h1 : 3'h0;
   wire logic ext_cfg   = cs_four | cs_thr;
   wire logic cfg_valid = ale_cfg | (sel_count != 3'h0);
   // Ready is not wired out in the latch-only mode
   wire logic rdy_cfg   = ~cs_ale;
   // Address pins left after selects and byte selects take theirs
   wire logic [4:0] reach_cs = ext_cfg ? hb_pkg::REACH_EXT :
                               cs_at ? hb_pkg::REACH_BASE - 5'h02 :
                               cs_two ? hb_pkg::REACH_BASE - 5'h01 :
                               hb_pkg::REACH_BASE;
   wire logic [4:0] reach = byte_lane_select_on ? reach_cs - hb_pkg::BYTE_LANE_SELECT_PINS
                                    : reach_cs;

   // Command fields
   wire logic       cmd_write = pwdata[hb_pkg::CMD_WR_BIT];
   wire logic [1:0] cmd_sel   = pwdata[hb_pkg::CMD_SEL_LSB +: 2];
   wire logic [1:0] cmd_be    = pwdata[hb_pkg::CMD_BE_LSB +: 2];
   wire logic sel_ok = (sel_count == 3'h0) || ({1'b0, cmd_sel} < sel_count);
   wire logic start  = start_req & (state == hb_pkg::ST_IDLE) & mode_ok
                     & cfg_valid & sel_ok;
   wire logic refuse_ev = start_req & ~start;
   wire logic [1:0] next_byte_lane_select_n = byte_lane_select_on ? ~cmd_be : 2'b11;
   logic [21:0] next_addr;
   logic [3:0]  next_sel_n;

   genvar i;
   for (i = 0; i < hb_pkg::ADDR_W; i++) begin : g_addr
      assign next_addr[i] = addr_reg[i] & (reach > 5'(i));
   end
   for (i = 0; i < 4; i++) begin : g_sel
      // Only one select of those that exist goes low
      assign next_sel_n[i] = ~((sel_count != 3'h0) && (cmd_sel == 2'(i)));
   end

   // Cycle sequencing
   wire logic in_cycle    = (state != hb_pkg::ST_IDLE);
   wire logic strobe_done = (state == hb_pkg::ST_STROBE) && (cnt == 4'h0)
                          && (~cyc_rdy | ready_s);

   always_comb begin
      next_state = state;
      case (state)
         hb_pkg::ST_IDLE:   if (start) next_state = hb_pkg::ST_SETUP;
         hb_pkg::ST_SETUP:  next_state = hb_pkg::ST_STROBE;
         hb_pkg::ST_STROBE: if (strobe_done) next_state = hb_pkg::ST_HOLD;
         hb_pkg::ST_HOLD:   next_state = hb_pkg::ST_IDLE;
         default:           next_state = hb_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= hb_pkg::ST_IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
      end else if (ce && state == hb_pkg::ST_SETUP) begin
         cnt <= hb_pkg::STROBE_MIN - 4'h1 + {2'b00, cyc_wait};
      end else if (ce && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end

   // Snapshot at start so a config write cannot move pins other than ext_en mid-cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cyc_write  <= 1'b0;
         cyc_ale    <= 1'b0;
         cyc_rdy    <= 1'b0;
         cyc_wait   <= 2'h0;
         cyc_addr   <= '0;
         cyc_sel_n  <= 4'hf;
         cyc_byte_lane_select_n <= 2'b11;
         cyc_wdata  <= 16'h0000;
      end else if (ce && start) begin
         cyc_write  <= cmd_write;
         cyc_ale    <= ale_cfg;
         cyc_rdy    <= rdy_cfg;
         cyc_wait   <= wait_cfg;
         cyc_addr   <= next_addr;
         cyc_sel_n  <= next_sel_n;
         cyc_byte_lane_select_n <= next_byte_lane_select_n;
         cyc_wdata  <= wdata_reg;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 16'h0000;
      end else if (ce && strobe_done && !cyc_write) begin
         rdata_reg <= data_s;
      end
   end

   // Pins; the two strobes both decode from ST_STROBE and are split by cyc_write
   assign bus_pins = '{
      addr:   cyc_addr,
      ale:    (state == hb_pkg::ST_SETUP) & cyc_ale,
      sel_n:  in_cycle ? cyc_sel_n : 4'hf,
      byte_lane_select_n: in_cycle ? cyc_byte_lane_select_n : 2'b11,
      rd_n:   ~((state == hb_pkg::ST_STROBE) & ~cyc_write),
      wr_n:   ~((state == hb_pkg::ST_STROBE) & cyc_write),
      ext_en: ext_cfg
   };
   assign data_out = cyc_wdata;
   assign data_oe  = in_cycle & cyc_write;

   // Register writes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         iface_top_config <= hb_pkg::TOP_RST;
      end else if (ce && wr_acc && hit_top) begin
         iface_top_config <= pwdata[hb_pkg::TOP_MODE_LSB +: 4];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hb_mode      <= hb_pkg::HB_MODE_RST;
         byte_sel_cfg <= hb_pkg::BYTE_LANE_SELECT_RST;
         wait_cfg     <= hb_pkg::WAIT_RST;
      end else if (ce && wr_acc && hit_cfg) begin
         hb_mode      <= pwdata[hb_pkg::HB_MODE_LSB +: 2];
         byte_sel_cfg <= pwdata[hb_pkg::HB_BYTE_LANE_SELECT_LSB +: 2];
         wait_cfg     <= pwdata[hb_pkg::HB_WAIT_LSB +: 2];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         select_config_field <= hb_pkg::CS_RST;
      end else if (ce && wr_acc && hit_cfg2) begin
         select_config_field <= pwdata[hb_pkg::CS_CFG_LSB +: 3];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         addr_reg  <= '0;
         wdata_reg <= 16'h0000;
      end else if (ce && wr_acc && hit_addr) begin
         addr_reg  <= pwdata[21:0];
      end else if (ce && wr_acc && hit_wd) begin
         wdata_reg <= pwdata[15:0];
      end
   end

   // Sticky refusal; a new refusal beats a clear in the same cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         refused <= 1'b0;
      end else if (ce && refuse_ev) begin
         refused <= 1'b1;
      end else if (ce && wr_stat && pwdata[hb_pkg::ST_REF_BIT]) begin
         refused <= 1'b0;
      end
   end

   // Read data is captured in the setup phase
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_top) begin
         rd_mux[hb_pkg::TOP_MODE_LSB +: 4] = iface_top_config;
      end else if (hit_cfg) begin
         rd_mux[hb_pkg::HB_MODE_LSB +: 2] = hb_mode;
         rd_mux[hb_pkg::HB_BYTE_LANE_SELECT_LSB +: 2] = byte_sel_cfg;
         rd_mux[hb_pkg::HB_WAIT_LSB +: 2] = wait_cfg;
      end else if (hit_cfg2) begin
         rd_mux[hb_pkg::CS_CFG_LSB +: 3] = select_config_field;
      end else if (hit_addr) begin
         rd_mux[21:0] = addr_reg;
      end else if (hit_wd) begin
         rd_mux[15:0] = wdata_reg;
      end else if (hit_rd) begin
         rd_mux[15:0] = rdata_reg;
      end else if (hit_st) begin
         rd_mux[hb_pkg::ST_BUSY_BIT] = in_cycle;
         rd_mux[hb_pkg::ST_REF_BIT]  = refused;
         rd_mux[hb_pkg::ST_RDY_BIT]  = ready_s;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (ce && psel && !penable) begin
         prdata <= rd_mux;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   // Checks
   sequence s_latch_then_strobe;
      !bus_pins.ale && (!bus_pins.rd_n || !bus_pins.wr_n);
   endsequence

   sequence s_refused_idle;
      (state == hb_pkg::ST_IDLE) && refused;
   endsequence

   strobe_excl_a: assert property (@(posedge clock) disable iff (!rst_n)
      !(!bus_pins.rd_n && !bus_pins.wr_n))
      else $error("read and write strobes overlap");

   pins_stable_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!bus_pins.rd_n || !bus_pins.wr_n) && $past(in_cycle)
      |-> $stable(bus_pins.addr) && $stable(bus_pins.sel_n)
          && $stable(bus_pins.byte_lane_select_n))
      else $error("address or selects moved under a strobe");

   ale_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus_pins.ale && ce |=> s_latch_then_strobe)
      else $error("latch strobe not followed by the data phase");

   mode_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
      start_req && !mode_ok && ce |=> s_refused_idle)
      else $error("cycle started outside host-bus-16 non-muxed mode");

   read_dir_a: assert property (@(posedge clock) disable iff (!rst_n)
      !bus_pins.rd_n |-> !cyc_write && !data_oe)
      else $error("read strobe in a write cycle");

   ready_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
      state == hb_pkg::ST_STROBE && cnt == 4'h0 && cyc_rdy && !ready_s
      && ce |=> state == hb_pkg::ST_STROBE)
      else $error("cycle ended while ready was low");

   no_byte_lane_select_a: assert property (@(posedge clock) disable iff (!rst_n)
      start && !byte_lane_select_on |=> bus_pins.byte_lane_select_n == 2'b11)
      else $error("byte selects driven while disabled");

   latch_only_a: assert property (@(posedge clock) disable iff (!rst_n)
      start && cs_ale |=> bus_pins.sel_n == 4'hf && bus_pins.ale)
      else $error("latch-only mode drove a select");

   one_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
      start && cs_one |=> bus_pins.sel_n == 4'he && !bus_pins.ale)
      else $error("single select mode wrong");
endmodule // hb_host16_port
`default_nettype wire

// ==== verilog/hb_sync.sv ====
/*
 Three-stage input synchroniser with a per-bit agreement filter.
 Assumes inputs that are asynchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hb_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] stable_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else if (ce) begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Stage one feeds stage two only; a bit moves once two stages agree
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            stable_out[i] <= 1'b0;
         end else if (ce && stage2[i] == stage3[i]) begin
            stable_out[i] <= stage2[i];
         end
      end
   end
endmodule // hb_sync
`default_nettype wire
